// ### rtl/hbis_top.sv
// Host bus interface: buffer control, bus sizing, local access, straps
`timescale 1ns/1ps
`default_nettype none
module hbis_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Power-on straps
  input  wire logic [15:0] pixel_bus_straps,
  // Host cycle inputs (pins)
  input  wire logic        processor_address_strobe,
  input  wire logic        cycle_is_write,
  input  wire logic        cycle_is_io,
  input  wire logic        cycle_is_dac,
  input  wire logic        cycle_is_bios,
  input  wire logic        graphics_hit,
  input  wire logic [19:11] bios_addr,
  input  wire logic        isa_sa16,
  input  wire logic        upper_addr_zero_low_group,
  input  wire logic        upper_addr_zero_high_group_in,
  input  wire logic        ready_return_in,
  // Host side outputs
  output var  logic        buffer_direction,
  output var  logic        low_byte_buffer_enable_n,
  output var  logic        high_byte_buffer_enable_n,
  output var  logic        memcs16_n_out,
  output var  logic        memcs16_n_oe,
  output var  logic        local_access_active_n_out,
  output var  logic        local_access_active_n_oe,
  output var  logic        device_ready_out_n,
  output var  logic        read_data_drive,
  output var  logic        bios_rom_select_n_out,
  output var  logic        bios_rom_select_n_oe,
  output var  logic        dac_write_strobe,
  output var  logic        bus_is_32bit,
  output var  logic        io_is_16bit
);
  // Synchronised pin inputs
  logic [15:0] strap_s1_reg, strap_s2_reg;
  logic [10:0] pin_s1_reg, pin_s2_reg;
  logic [19:11] ba_s1_reg, ba_s2_reg;
  logic        ads_d_reg;
  always_ff @(posedge aclk) begin
    strap_s1_reg <= pixel_bus_straps;
    strap_s2_reg <= strap_s1_reg;
    pin_s1_reg   <= {processor_address_strobe, cycle_is_write, cycle_is_io,
                     cycle_is_dac, cycle_is_bios, graphics_hit, isa_sa16,
                     upper_addr_zero_low_group, upper_addr_zero_high_group_in,
                     ready_return_in, 1'b0};
    pin_s2_reg   <= pin_s1_reg;
    ba_s1_reg    <= bios_addr;
    ba_s2_reg    <= ba_s1_reg;
  end
  wire ads_s   = pin_s2_reg[10];
  wire wr_s    = pin_s2_reg[9];
  wire io_s    = pin_s2_reg[8];
  wire dac_s   = pin_s2_reg[7];
  wire bios_s  = pin_s2_reg[6];
  wire hit_s   = pin_s2_reg[5];
  wire sa16_s  = pin_s2_reg[4];
  wire up_lo_s = pin_s2_reg[3];
  wire up_hi_s = pin_s2_reg[2];
  wire ready_return_in_s = pin_s2_reg[1];

  // Strap capture at reset release
  logic [15:0] cfg_reg;
  logic        in_reset_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_reset_reg <= 1'b1;
      cfg_reg      <= 16'h0000;
    end else begin
      in_reset_reg <= 1'b0;
      if (in_reset_reg)
        cfg_reg <= strap_s2_reg;
    end
  end
  wire [1:0] bus_type = cfg_reg[hbis_pkg::STRAP_BUS_LSB +: 2];
  wire is_local = (bus_type == hbis_pkg::BUS_LOCAL);
  wire is_isa   = (bus_type == hbis_pkg::BUS_ISA);
  wire st_bios  = cfg_reg[hbis_pkg::STRAP_BIOS_BIT];
  wire st_rom   = cfg_reg[hbis_pkg::STRAP_ROM_BIT];
  wire st_en    = cfg_reg[hbis_pkg::STRAP_EN_BIT];
  wire st_tri   = cfg_reg[hbis_pkg::STRAP_LOCAL_ACCESS_ACTIVE_BIT];
  wire st_m16   = cfg_reg[hbis_pkg::STRAP_M16_BIT];

  // Software registers
  logic [7:0] misc_reg, syscf_reg;
  wire mem16   = misc_reg[hbis_pkg::MISC_MEM16_BIT];
  wire [1:0] dwait = syscf_reg[hbis_pkg::SYSCF_WAIT_LSB +: 2];

  // BIOS window decode
  wire bios_in  = (ba_s2_reg[19:15] == hbis_pkg::BIOS_BASE_HI);
  wire bios_hole = (ba_s2_reg == hbis_pkg::BIOS_HOLE);
  wire bios_hit = bios_s && bios_in && (st_bios || !bios_hole);
  // Upper address qualification; the high group pin is lost in ROM mode
  wire rom_mode = is_local && !st_rom;
  wire upper_ok = up_lo_s && (rom_mode || up_hi_s);
  // DAC accesses go local only when strap 12 is high
  wire dac_local = !dac_s || st_m16;
  wire claim = is_local && st_en && hit_s && upper_ok && dac_local;
  wire ads_rise = ads_s && !ads_d_reg;

  // Local bus cycle sequencer
  hbis_pkg::hbis_state_t state_reg, state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hbis_pkg::HBIS_IDLE:
        if (ads_rise && claim) state_next = hbis_pkg::HBIS_T2A;
      hbis_pkg::HBIS_T2A:
        state_next = (dwait == hbis_pkg::WAIT_NONE) ? hbis_pkg::HBIS_RDY
                                                    : hbis_pkg::HBIS_T2B;
      hbis_pkg::HBIS_T2B: state_next = hbis_pkg::HBIS_RDY;
      hbis_pkg::HBIS_RDY:
        state_next = wr_s ? hbis_pkg::HBIS_HIGH : hbis_pkg::HBIS_HOLD;
      hbis_pkg::HBIS_HOLD:
        if (ready_return_in_s) state_next = hbis_pkg::HBIS_HIGH;
      hbis_pkg::HBIS_HIGH: state_next = hbis_pkg::HBIS_IDLE;
      default: state_next = hbis_pkg::HBIS_IDLE;
    endcase
  end

  // Local access drive: three-state or level form
  logic local_access_active_low, local_access_active_oe_n;
  logic level_low_reg;
  logic float_reg;
  wire in_t2 = (state_reg == hbis_pkg::HBIS_T2A) ||
               (state_reg == hbis_pkg::HBIS_T2B);
  wire tri_low = (state_reg == hbis_pkg::HBIS_RDY) ||
                 (state_reg == hbis_pkg::HBIS_HOLD) ||
                 (in_t2 && (dwait == hbis_pkg::WAIT_NONE ||
                            state_reg == hbis_pkg::HBIS_T2B));
  always_comb begin
    if (st_tri) begin
      local_access_active_low  = tri_low;
      local_access_active_oe_n = !(tri_low || (state_reg == hbis_pkg::HBIS_HIGH) ||
                    !float_reg);
    end else begin
      local_access_active_low  = level_low_reg;
      local_access_active_oe_n = 1'b0;
    end
  end

  wire memcs_drive = is_isa && mem16 && !io_s;
  wire memcs_val_n = st_m16 ? !hit_s : !mem16;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg                 <= hbis_pkg::HBIS_IDLE;
      ads_d_reg                 <= 1'b0;
      level_low_reg             <= 1'b0;
      float_reg                 <= 1'b1;
      buffer_direction          <= 1'b0;
      low_byte_buffer_enable_n  <= 1'b1;
      high_byte_buffer_enable_n <= 1'b1;
      memcs16_n_out             <= 1'b1;
      memcs16_n_oe              <= 1'b1;
      local_access_active_n_out <= 1'b1;
      local_access_active_n_oe  <= 1'b1;
      device_ready_out_n        <= 1'b1;
      read_data_drive           <= 1'b0;
      bios_rom_select_n_out     <= 1'b1;
      bios_rom_select_n_oe      <= 1'b1;
      dac_write_strobe          <= 1'b0;
      bus_is_32bit              <= 1'b0;
      io_is_16bit               <= 1'b0;
    end else begin
      state_reg <= state_next;
      ads_d_reg <= ads_s;
      // Level form stays low until the next cycle's strobe (its T1)
      if (ads_rise)
        level_low_reg <= claim;
      // Release during first T2 of the next cycle
      if (state_reg == hbis_pkg::HBIS_HIGH)
        float_reg <= 1'b0;
      else if (state_reg == hbis_pkg::HBIS_T2A || !float_reg && ads_rise)
        float_reg <= 1'b1;
      buffer_direction <= wr_s;
      low_byte_buffer_enable_n  <= !(hit_s || bios_hit);
      high_byte_buffer_enable_n <= !((hit_s && (io_s ? !dac_s : mem16)) ||
                                     (bios_hit && mem16));
      memcs16_n_out <= memcs_val_n;
      memcs16_n_oe  <= !memcs_drive;
      local_access_active_n_out <= !local_access_active_low;
      local_access_active_n_oe  <= local_access_active_oe_n;
      device_ready_out_n <= !(state_reg == hbis_pkg::HBIS_RDY);
      read_data_drive <= (state_reg == hbis_pkg::HBIS_RDY && !wr_s) ||
                         (state_reg == hbis_pkg::HBIS_HOLD && !ready_return_in_s);
      bios_rom_select_n_out <= !bios_hit;
      bios_rom_select_n_oe  <= !rom_mode;
      // DAC writes reach the local DAC even when not claimed
      dac_write_strobe <= ads_rise && dac_s && wr_s && hit_s;
      bus_is_32bit <= is_local;
      io_is_16bit  <= is_isa && !dac_s;
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  logic aw_hold_reg, w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire wr_misc  = (awaddr_reg == hbis_pkg::ADDR_MISC);
  wire wr_syscf = (awaddr_reg == hbis_pkg::ADDR_SYSCF);
  wire wr_ok    = wr_misc || wr_syscf || awaddr_reg == hbis_pkg::ADDR_CFG1 ||
                  awaddr_reg == hbis_pkg::ADDR_CFG2 ||
                  awaddr_reg == hbis_pkg::ADDR_STAT;
  wire [31:0] stat_word = {24'h000000, 2'h0, is_local, is_isa,
                           memcs_drive, rom_mode, st_en, st_tri};
  wire [31:0] rd_word =
    (s_axi_araddr == hbis_pkg::ADDR_MISC)  ? {24'h000000, misc_reg}  :
    (s_axi_araddr == hbis_pkg::ADDR_SYSCF) ? {24'h000000, syscf_reg} :
    (s_axi_araddr == hbis_pkg::ADDR_CFG1)  ? {24'h000000, cfg_reg[7:0]} :
    (s_axi_araddr == hbis_pkg::ADDR_CFG2)  ? {24'h000000, cfg_reg[15:8]} :
    (s_axi_araddr == hbis_pkg::ADDR_STAT)  ? stat_word : 32'h00000000;
  wire rd_ok = s_axi_araddr == hbis_pkg::ADDR_MISC ||
               s_axi_araddr == hbis_pkg::ADDR_SYSCF ||
               s_axi_araddr == hbis_pkg::ADDR_CFG1 ||
               s_axi_araddr == hbis_pkg::ADDR_CFG2 ||
               s_axi_araddr == hbis_pkg::ADDR_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= hbis_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= hbis_pkg::RESP_OKAY;
      misc_reg      <= hbis_pkg::MISC_RESET;
      syscf_reg     <= hbis_pkg::SYSCF_RESET;
    end else begin
      s_axi_awready <= !aw_hold_reg && !aw_take;
      s_axi_wready  <= !w_hold_reg && !w_take;
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? hbis_pkg::RESP_OKAY : hbis_pkg::RESP_SLVERR;
        if (wr_misc && wstrb_reg[0])
          misc_reg <= wdata_reg[7:0];
        if (wr_syscf && wstrb_reg[0])
          syscf_reg <= wdata_reg[7:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? hbis_pkg::RESP_OKAY : hbis_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  ready_one_clk_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !device_ready_out_n |=> device_ready_out_n)
    else $error("ready held more than one clock");
  memcs_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(mem16) && !mem16 |-> memcs16_n_oe)
    else $error("MEMCS16 driven in 8-bit mode");
  bus32_local_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(is_local) |-> bus_is_32bit)
    else $error("local bus not 32 bit");
  dir_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> buffer_direction == $past(wr_s))
    else $error("buffer direction wrong");
  wait_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == hbis_pkg::HBIS_T2A && dwait == hbis_pkg::WAIT_NONE
    |=> state_reg == hbis_pkg::HBIS_RDY ##1 !device_ready_out_n)
    else $error("no-wait ready late");
  level_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && !st_tri && $past(!st_tri)
    |-> !local_access_active_n_oe)
    else $error("level form floated");
  hold_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == hbis_pkg::HBIS_HOLD && !ready_return_in_s |=> read_data_drive)
    else $error("read data dropped early");
  dac_suppress_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == hbis_pkg::HBIS_IDLE && ads_rise && dac_s && !st_m16
    |=> state_reg == hbis_pkg::HBIS_IDLE)
    else $error("DAC cycle claimed with strap low");
  disabled_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_en && state_reg == hbis_pkg::HBIS_IDLE |=>
    state_reg == hbis_pkg::HBIS_IDLE)
    else $error("disabled device claimed cycle");
endmodule : hbis_top
`default_nettype wire

// ### include/hbis_pkg.sv
// Constants for the host bus interface and power-on strap block
package hbis_pkg;
  // Register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] ADDR_MISC  = 8'h00; // misc control (video mem width)
  localparam logic [7:0] ADDR_SYSCF = 8'h04; // system config (decode wait)
  localparam logic [7:0] ADDR_CFG1  = 8'h08; // strap capture low byte
  localparam logic [7:0] ADDR_CFG2  = 8'h0C; // strap capture high byte
  localparam logic [7:0] ADDR_STAT  = 8'h10; // live status
  // Documented register indices kept for reference
  localparam logic [7:0] IDX_MISC  = 8'h3A;
  localparam logic [7:0] IDX_SYSCF = 8'h40;
  localparam logic [7:0] IDX_CFG1  = 8'h36;
  localparam logic [7:0] IDX_CFG2  = 8'h37;
  // Field positions
  localparam int MISC_MEM16_BIT  = 7;
  localparam int SYSCF_WAIT_LSB  = 4;
  localparam int STRAP_BUS_LSB   = 0;
  localparam int STRAP_BIOS_BIT  = 3;
  localparam int STRAP_ROM_BIT   = 4;
  localparam int STRAP_EN_BIT    = 8;
  localparam int STRAP_LOCAL_ACCESS_ACTIVE_BIT  = 11;
  localparam int STRAP_M16_BIT   = 12;
  // Bus type codes
  localparam logic [1:0] BUS_EISA  = 2'h0;
  localparam logic [1:0] BUS_LOCAL = 2'h1;
  localparam logic [1:0] BUS_ISA   = 2'h3;
  // Decode wait codes
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_ONE  = 2'h1;
  // Reset values
  localparam logic [7:0] MISC_RESET  = 8'h00;
  localparam logic [7:0] SYSCF_RESET = 8'h00;
  // BIOS window, address bits [19:11] in 2 KiB units
  localparam logic [19:15] BIOS_BASE_HI = 5'h18; // C0000-C7FFF
  localparam logic [19:11] BIOS_HOLE    = 9'h18C; // C6000-C67FF
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Local bus cycle states
  typedef enum logic [2:0] {
    HBIS_IDLE, HBIS_T2A, HBIS_T2B, HBIS_RDY, HBIS_HOLD, HBIS_HIGH
  } hbis_state_t;
endpackage : hbis_pkg

// ### verif/hbis_host_model.sv
// Host-side partner: runs local bus cycles and returns the ready it sees
`timescale 1ns/1ps
`default_nettype none
module hbis_host_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Bench requests
  input  wire logic       start,
  input  wire logic       wr,
  input  wire logic       dac,
  input  wire logic [1:0] rdy_delay,
  // Device side
  input  wire logic       device_ready_out_n,
  output var  logic       processor_address_strobe,
  output var  logic       cycle_is_write,
  output var  logic       cycle_is_dac,
  output var  logic       graphics_hit,
  output var  logic       upper_addr_zero_low_group,
  output var  logic       upper_addr_zero_high_group_in,
  output var  logic       ready_return_in
);
  logic       busy_reg;
  logic [2:0] rdy_pipe_reg;
  // Returns the ready the processor sees, direct or resynchronised
  assign ready_return_in = busy_reg && ((rdy_delay == 2'h0) ?
    !device_ready_out_n : rdy_pipe_reg[rdy_delay - 2'h1]);
  // Cycle address always lies where both upper groups are zero
  assign upper_addr_zero_low_group     = busy_reg;
  assign upper_addr_zero_high_group_in = busy_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg                 <= 1'b0;
      processor_address_strobe <= 1'b0;
      cycle_is_write           <= 1'b0;
      cycle_is_dac             <= 1'b0;
      graphics_hit             <= 1'b0;
      rdy_pipe_reg             <= 3'h0;
    end else begin
      rdy_pipe_reg <= {rdy_pipe_reg[1:0], !device_ready_out_n};
      if (start && !busy_reg) begin
        busy_reg                 <= 1'b1;
        processor_address_strobe <= 1'b1;
        cycle_is_write           <= wr;
        cycle_is_dac             <= dac;
        graphics_hit             <= 1'b1;
      end
      if (!device_ready_out_n) processor_address_strobe <= 1'b0;
      // Released write and DAC lines flip, and the hit line clears, so a stale level cannot pass as valid
      if (ready_return_in) begin
        busy_reg       <= 1'b0;
        cycle_is_write <= !cycle_is_write;
        cycle_is_dac   <= !cycle_is_dac;
        graphics_hit   <= 1'b0;
      end
    end
  end
endmodule : hbis_host_model
`default_nettype wire

// ### verif/hbis_top_test.sv
// Self-checking bench for the host bus interface and strap block
`timescale 1ns/1ps
`default_nettype none
module hbis_top_test;
  logic        aclk, aresetn, start, wr, dac;
  logic [1:0]  rdly, s_axi_bresp, s_axi_rresp;
  logic [15:0] pixel_bus_straps;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        strobe, is_wr, is_dac, hit, up_lo, up_hi, rdy_ret;
  logic        memcs_n, memcs_oe, local_access_active_n, local_access_active_oe, ready_n, rd_drive;
  logic        buffer_direction, rom_oe, dac_stb, bus32, io16;
  logic        lo_en, hi_en, bios;
  logic [19:11] baddr;
  int          err_count, n_tests, l0, l1;

  hbis_top u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pixel_bus_straps,
    .processor_address_strobe(strobe), .cycle_is_write(is_wr),
    .cycle_is_io(1'b0), .cycle_is_dac(is_dac), .cycle_is_bios(bios),
    .graphics_hit(hit), .bios_addr(baddr), .isa_sa16(1'b0),
    .upper_addr_zero_low_group(up_lo),
    .upper_addr_zero_high_group_in(up_hi), .ready_return_in(rdy_ret),
    .buffer_direction, .low_byte_buffer_enable_n(lo_en),
    .high_byte_buffer_enable_n(hi_en), .memcs16_n_out(memcs_n),
    .memcs16_n_oe(memcs_oe), .local_access_active_n_out(local_access_active_n),
    .local_access_active_n_oe(local_access_active_oe), .device_ready_out_n(ready_n),
    .read_data_drive(rd_drive), .bios_rom_select_n_out(),
    .bios_rom_select_n_oe(rom_oe), .dac_write_strobe(dac_stb),
    .bus_is_32bit(bus32), .io_is_16bit(io16));

  hbis_host_model u_host (
    .aclk, .aresetn, .start, .wr, .dac, .rdy_delay(rdly),
    .device_ready_out_n(ready_n), .processor_address_strobe(strobe),
    .cycle_is_write(is_wr), .cycle_is_dac(is_dac), .graphics_hit(hit),
    .upper_addr_zero_low_group(up_lo),
    .upper_addr_zero_high_group_in(up_hi), .ready_return_in(rdy_ret));

  // Free-running, also through reset
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic timeout();
    err_count++;
    $display("wait limit used up at %0t", $time);
    results();
  endtask : timeout

  // Straps flip after capture, so a late sample shows up
  task automatic do_reset(input logic [15:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    start <= 1'b0;
    pixel_bus_straps <= s;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    pixel_bus_straps <= ~s;
    @(posedge aclk);
  endtask : do_reset

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic b;
    n = 0;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      if (++n > 40) timeout();
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic b;
    n = 0;
    b = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      b = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (++n > 40) timeout();
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic t_cfg();
    logic [15:0] s;
    logic [31:0] d;
    logic [1:0]  r;
    logic [1:0]  c;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) continue;
      c = 2'(i);
      s = {8'h93, 3'b000, c != hbis_pkg::BUS_LOCAL, 2'b00, c};
      do_reset(s);
      axi_rd(hbis_pkg::ADDR_CFG1, d, r);
      chk(d, {24'h0, s[7:0]});
      axi_rd(hbis_pkg::ADDR_CFG2, d, r);
      chk(d, {24'h0, s[15:8]});
      chk(bus32, c == hbis_pkg::BUS_LOCAL);
      chk(io16, c == hbis_pkg::BUS_ISA);
      chk(rom_oe, c != hbis_pkg::BUS_LOCAL);
    end
    $display("t_cfg done");
  endtask : t_cfg

  task automatic t_misc();
    logic [31:0] d;
    logic [1:0]  r;
    do_reset(16'h0313);
    chk(memcs_oe, 1'b1);
    axi_rd(hbis_pkg::ADDR_MISC, d, r);
    chk(d, {24'h0, hbis_pkg::MISC_RESET});
    axi_wr(hbis_pkg::ADDR_MISC, 32'h0000_0080, r);
    axi_rd(hbis_pkg::ADDR_MISC, d, r);
    chk(d[7], 1'b1);
    repeat (3) @(posedge aclk);
    chk({memcs_oe, memcs_n}, 2'b00);
    axi_wr(hbis_pkg::ADDR_SYSCF, 32'h0000_0010, r);
    axi_rd(hbis_pkg::ADDR_SYSCF, d, r);
    chk(d[5:4], hbis_pkg::WAIT_ONE);
    axi_wr(hbis_pkg::ADDR_CFG1, 32'h0000_00FF, r);
    chk(r, hbis_pkg::RESP_OKAY);
    axi_rd(hbis_pkg::ADDR_CFG1, d, r);
    chk(d, 32'h0000_0013);
    axi_rd(8'h20, d, r);
    chk(r, hbis_pkg::RESP_SLVERR);
    axi_wr(hbis_pkg::ADDR_MISC, 32'h0000_0000, r);
    repeat (3) @(posedge aclk);
    chk(memcs_oe, 1'b1);
    // Strap 3 is low here, so the hole inside the BIOS window is dead
    bios <= 1'b1;
    baddr <= 9'h180;
    repeat (4) @(posedge aclk);
    chk({hi_en, lo_en}, 2'b10);
    baddr <= hbis_pkg::BIOS_HOLE;
    repeat (4) @(posedge aclk);
    chk({hi_en, lo_en}, 2'b11);
    bios <= 1'b0;
    $display("t_misc done");
  endtask : t_misc

  task automatic t_cycle(input logic ts, input logic [1:0] wt,
                         input logic w, input logic [1:0] dl, output int lat);
    logic [1:0]  r;
    logic        pl, po;
    int          k;
    do_reset({3'b000, 1'b1, ts, 2'b01, 1'b1, 3'b000, 1'b1, 2'b00, 2'b01});
    axi_wr(hbis_pkg::ADDR_SYSCF, {26'h0, wt, 4'h0}, r);
    wr <= w;
    dac <= 1'b0;
    rdly <= dl;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    lat = 0;
    while (ready_n !== 1'b0) begin
      pl = local_access_active_n;
      po = local_access_active_oe;
      @(posedge aclk);
      if (++lat > 40) timeout();
    end
    chk({po, pl}, 2'b00);
    chk(buffer_direction, w);
    if (!w) chk(rd_drive, 1'b1);
    @(posedge aclk);
    chk(ready_n, 1'b1);
    k = 0;
    while (rd_drive === 1'b1) begin
      @(posedge aclk);
      if (++k > 20) timeout();
    end
    if (!w) chk(k > 32'(dl), 1'b1);
    repeat (4) @(posedge aclk);
    chk({local_access_active_oe, local_access_active_n}, {1'b0, ts});
    $display("t_cycle done");
  endtask : t_cycle

  task automatic t_noclaim(input logic s12, input logic s8, input logic d);
    logic sr, sl, sw;
    sr = 1'b0;
    sl = 1'b0;
    sw = 1'b0;
    do_reset({3'b000, s12, 3'b001, s8, 3'b000, 1'b1, 2'b00, 2'b01});
    wr <= 1'b1;
    dac <= d;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    repeat (20) begin
      @(posedge aclk);
      sr |= !ready_n;
      sl |= !local_access_active_n;
      sw |= dac_stb;
    end
    chk({sr, sl, sw}, {2'b00, d});
    $display("t_noclaim done");
  endtask : t_noclaim

  initial begin
    aresetn = 1'b0;
    pixel_bus_straps = 16'h0000;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {start, wr, dac, rdly} = 5'h00;
    {bios, baddr} = 10'h000;
    t_cfg();
    t_misc();
    t_cycle(1'b1, 2'h0, 1'b1, 2'h0, l0);
    t_cycle(1'b1, 2'h1, 1'b1, 2'h0, l1);
    chk(32'(l1), 32'(l0 + 1));
    t_cycle(1'b0, 2'h0, 1'b0, 2'h2, l0);
    t_noclaim(1'b0, 1'b1, 1'b1);
    t_noclaim(1'b1, 1'b0, 1'b0);
    results();
  end
endmodule : hbis_top_test
`default_nettype wire
